/* design/pwg_defines.svh */
// Offsets, field positions, reset values and masks of the write guard
`ifndef PWG_DEFINES_SVH
`define PWG_DEFINES_SVH

`define PWG_DATA_W 32
`define PWG_ADDR_W 12
`define PWG_NUM_BRIDGE 3

// Per-controller window and in-window offsets
`define PWG_CTRL_STRIDE 12'h100
`define PWG_OFS_CLEAR 8'h00
`define PWG_OFS_SET 8'h04

// Shared control and status words
`define PWG_ADDR_CLKEN 12'h300
`define PWG_ADDR_STATUS 12'h304
`define PWG_ADDR_CHKCNT 12'h308

// Bridge A slots
`define PWG_A_BIT_EXT_INT 6
`define PWG_A_BIT_RTC 5
`define PWG_A_BIT_WATCHDOG 4
`define PWG_A_BIT_CLKGEN 3
`define PWG_A_BIT_SYSCTL 2
`define PWG_A_BIT_PWRMGR 1
`define PWG_A_MASK 32'h0000007e
`define PWG_A_RESET 32'h00000000

// Bridge B slots
`define PWG_B_BIT_TRACE 6
`define PWG_B_BIT_PINPORT 3
`define PWG_B_BIT_FLASH 2
`define PWG_B_BIT_DEBUG 1
`define PWG_B_MASK 32'h0000004e
`define PWG_B_RESET 32'h00000002

// Bridge C slots
`define PWG_C_MASK 32'h000fff7e
`define PWG_C_RESET 32'h00000000

// Bus clock enables: A and B on, C off
`define PWG_CLKEN_RESET 3'h3
`define PWG_CLKEN_W 3

// Status: one sticky blocked flag per bridge
`define PWG_STATUS_W 3
`define PWG_CNT_W 16
`define PWG_STATUS_RESET 3'h0
`define PWG_CNT_RESET 16'h0000
`define PWG_CNT_MAX 16'hffff

`endif

/* design/pwg_pkg.sv */
// Types shared by the write guard design
package pwg_pkg;

   typedef struct packed {
      logic valid;
      logic [1:0] bridge;
      logic [4:0] slot;
      logic debug;
   } pwg_chk_req_type;

   typedef struct packed {
      logic done;
      logic allow;
      logic block;
   } pwg_chk_rsp_type;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pwg_bus_req_type;

endpackage : pwg_pkg

/* design/pwg_guard_unit.sv */
// One protection controller: protect bits with clear and set access
`include "pwg_defines.svh"

module pwg_guard_unit #(
   parameter logic [31:0] MASK = 32'h00000000,
   parameter logic [31:0] RESET_VAL = 32'h00000000
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic active_in,
   input wire logic clear_wr_in,
   input wire logic set_wr_in,
   input wire logic [31:0] wdata_in,
   output logic [31:0] protect_out
);

   logic [31:0] protect_reg;
   logic [31:0] protect_next;
   wire logic [31:0] clr_bits;
   wire logic [31:0] set_bits;
   wire logic do_clr;
   wire logic do_set;

   // Writes only land while this controller's bus clock runs
   assign do_clr = active_in & clear_wr_in;
   assign do_set = active_in & set_wr_in;
   // Zero bits leave the state alone; unassigned bits are dropped
   assign clr_bits = do_clr ? (wdata_in & MASK) : 32'h00000000;
   assign set_bits = do_set ? (wdata_in & MASK) : 32'h00000000;
   assign protect_next = ((protect_reg & ~clr_bits) | set_bits)
                         & MASK;

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         protect_reg <= RESET_VAL;
      end else begin
         protect_reg <= protect_next;
      end
   end

   assign protect_out = protect_reg;

endmodule // pwg_guard_unit

/* design/pwg_top.sv */
// Peripheral write guard: three bridge controllers and register port
//
// Chosen here: the plain strobed port.
`include "pwg_defines.svh"

module pwg_top (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire pwg_pkg::pwg_bus_req_type bus_req_in,
   input wire logic src_clk_run_in,
   input wire pwg_pkg::pwg_chk_req_type chk_req_in,
   output logic [31:0] rdata_out,
   output pwg_pkg::pwg_chk_rsp_type chk_rsp_out,
   output logic [2:0] bus_clk_en_out,
   output logic [31:0] protect_a_out,
   output logic [31:0] protect_b_out,
   output logic [31:0] protect_c_out
);

   // Address helpers
   function automatic logic [1:0] ctrl_index(input logic [11:0] a);
      ctrl_index = a[9:8];
   endfunction

   function automatic logic is_ofs(input logic [11:0] a,
                                   input logic [7:0] ofs);
      is_ofs = (a[7:0] == ofs) && (a[11:10] == 2'h0)
               && (a[9:8] != 2'h3);
   endfunction

   function automatic logic bit_of(input logic [31:0] v,
                                   input logic [4:0] idx);
      bit_of = v[idx];
   endfunction

   // One-hot select of a controller index; index 3 selects none
   function automatic logic [2:0] onehot_of(input logic [1:0] idx);
      case (idx)
         2'h0: onehot_of = 3'h1;
         2'h1: onehot_of = 3'h2;
         2'h2: onehot_of = 3'h4;
         default: onehot_of = 3'h0;
      endcase
   endfunction

   // Protect word of a controller index; index 3 reads zero
   function automatic logic [31:0] prot_of(input logic [1:0] idx,
                                           input logic [31:0] va,
                                           input logic [31:0] vb,
                                           input logic [31:0] vc);
      case (idx)
         2'h0: prot_of = va;
         2'h1: prot_of = vb;
         2'h2: prot_of = vc;
         default: prot_of = 32'h00000000;
      endcase
   endfunction

   // Zero-extends a three-bit control or status field
   function automatic logic [31:0] zext3(input logic [2:0] v);
      zext3 = {29'h0, v};
   endfunction

   // Register state
   logic [2:0] clk_en_reg;
   logic [2:0] clk_en_next;
   logic [2:0] status_reg;
   logic [2:0] status_next;
   logic [15:0] chk_cnt_reg;
   logic [15:0] chk_cnt_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic chk_done_reg;
   logic chk_allow_reg;
   logic chk_block_reg;
   logic [2:0] clk_en_out_reg;

   // Bus fields
   wire logic [11:0] addr;
   wire logic [31:0] wdata;
   wire logic wr;
   wire logic rd;
   assign addr = bus_req_in.addr;
   assign wdata = bus_req_in.wdata;
   assign wr = bus_req_in.wr;
   assign rd = bus_req_in.rd;

   // Decode
   wire logic [1:0] sel_ctrl;
   wire logic hit_clear;
   wire logic hit_set;
   wire logic hit_clken;
   wire logic hit_status;
   wire logic hit_chkcnt;
   assign sel_ctrl = ctrl_index(addr);
   assign hit_clear = is_ofs(addr, `PWG_OFS_CLEAR);
   assign hit_set = is_ofs(addr, `PWG_OFS_SET);
   assign hit_clken = (addr == `PWG_ADDR_CLKEN);
   assign hit_status = (addr == `PWG_ADDR_STATUS);
   assign hit_chkcnt = (addr == `PWG_ADDR_CHKCNT);

   wire logic [2:0] ctrl_sel;
   assign ctrl_sel = onehot_of(sel_ctrl);

   // Controller runs only with its enable and a live clock source
   wire logic [2:0] ctrl_active;
   assign ctrl_active = clk_en_reg & {3{src_clk_run_in}};

   wire logic [2:0] clear_wr;
   wire logic [2:0] set_wr;
   assign clear_wr = ctrl_sel & {3{wr & hit_clear}};
   assign set_wr = ctrl_sel & {3{wr & hit_set}};

   // Register writes qualified by their decode
   wire logic wr_clken;
   wire logic wr_status;
   wire logic wr_chkcnt;
   wire logic [2:0] wdata_lo3;
   assign wr_clken = wr & hit_clken;
   assign wr_status = wr & hit_status;
   assign wr_chkcnt = wr & hit_chkcnt;
   assign wdata_lo3 = wdata[2:0];

   wire logic [31:0] prot_a;
   wire logic [31:0] prot_b;
   wire logic [31:0] prot_c;

   // One controller per bridge
   pwg_guard_unit #(
      .MASK(`PWG_A_MASK),
      .RESET_VAL(`PWG_A_RESET)
   ) u_guard_a (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .active_in(ctrl_active[0]),
      .clear_wr_in(clear_wr[0]),
      .set_wr_in(set_wr[0]),
      .wdata_in(wdata),
      .protect_out(prot_a)
   );

   pwg_guard_unit #(
      .MASK(`PWG_B_MASK),
      .RESET_VAL(`PWG_B_RESET)
   ) u_guard_b (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .active_in(ctrl_active[1]),
      .clear_wr_in(clear_wr[1]),
      .set_wr_in(set_wr[1]),
      .wdata_in(wdata),
      .protect_out(prot_b)
   );

   pwg_guard_unit #(
      .MASK(`PWG_C_MASK),
      .RESET_VAL(`PWG_C_RESET)
   ) u_guard_c (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .active_in(ctrl_active[2]),
      .clear_wr_in(clear_wr[2]),
      .set_wr_in(set_wr[2]),
      .wdata_in(wdata),
      .protect_out(prot_c)
   );

   // Clock enable register
   assign clk_en_next = wr_clken ? wdata_lo3 : clk_en_reg;

   // Write check: slot protect bit of the addressed bridge only
   wire logic [2:0] chk_sel;
   wire logic [31:0] chk_vec;
   wire logic chk_prot;
   wire logic chk_bridge_ok;
   wire logic chk_allow;
   wire logic chk_block;
   assign chk_sel = onehot_of(chk_req_in.bridge);
   assign chk_bridge_ok = |chk_sel;
   assign chk_vec = prot_of(chk_req_in.bridge,
                            prot_a, prot_b, prot_c);
   assign chk_prot = bit_of(chk_vec, chk_req_in.slot);
   assign chk_allow = chk_req_in.valid & chk_bridge_ok
                      & (chk_req_in.debug | ~chk_prot);
   assign chk_block = chk_req_in.valid & chk_bridge_ok
                      & ~chk_req_in.debug & chk_prot;

   // Sticky blocked flags per bridge; a new block wins over a clear
   wire logic [2:0] block_evt;
   wire logic [2:0] status_clr;
   assign block_evt = chk_sel & {3{chk_block}};
   assign status_clr = wr_status ? wdata_lo3 : 3'h0;
   assign status_next = (status_reg & ~status_clr) | block_evt;

   // Saturating count of blocked writes, cleared by a write to PWG_ADDR_CHKCNT; a block in the same cycle wins
   wire logic cnt_full;
   wire logic [15:0] cnt_inc;
   wire logic cnt_clr;
   assign cnt_full = (chk_cnt_reg == `PWG_CNT_MAX);
   assign cnt_inc = chk_cnt_reg + 16'h0001;
   assign cnt_clr = wr_chkcnt & ~chk_block;
   assign chk_cnt_next = (chk_block && !cnt_full) ? cnt_inc :
                         cnt_clr ? 16'h0000 : chk_cnt_reg;

   // Read mux: clear and set return the same protect state
   wire logic [31:0] prot_sel;
   assign prot_sel = prot_of(sel_ctrl, prot_a, prot_b, prot_c);

   wire logic rd_hit_prot;
   wire logic rd_mapped;
   wire logic [31:0] rd_word;
   assign rd_hit_prot = hit_clear | hit_set;
   assign rd_mapped = rd_hit_prot | hit_clken | hit_status | hit_chkcnt;
   assign rd_word = rd_hit_prot ? prot_sel :
                    hit_clken ? zext3(clk_en_reg) :
                    hit_status ? zext3(status_reg) :
                    hit_chkcnt ? {16'h0, chk_cnt_reg} :
                    32'h00000000;
   assign rdata_next = (rd && rd_mapped) ? rd_word : 32'h00000000;

   // Bus clock enable state
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         clk_en_reg <= `PWG_CLKEN_RESET;
      end else begin
         clk_en_reg <= clk_en_next;
      end
   end

   // Enable copy driving the output pins
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         clk_en_out_reg <= `PWG_CLKEN_RESET;
      end else begin
         clk_en_out_reg <= clk_en_next;
      end
   end

   // Sticky blocked flags
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         status_reg <= `PWG_STATUS_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   // Blocked write count
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         chk_cnt_reg <= `PWG_CNT_RESET;
      end else begin
         chk_cnt_reg <= chk_cnt_next;
      end
   end

   // Check answer, one cycle after the request
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         chk_done_reg <= 1'b0;
      end else begin
         chk_done_reg <= chk_req_in.valid;
      end
   end

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         chk_allow_reg <= 1'b0;
         chk_block_reg <= 1'b0;
      end else begin
         chk_allow_reg <= chk_allow;
         chk_block_reg <= chk_block;
      end
   end

   // Read data, standing for one cycle
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_reg <= 32'h00000000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Outputs
   assign rdata_out = rdata_reg;
   assign chk_rsp_out.done = chk_done_reg;
   assign chk_rsp_out.allow = chk_allow_reg;
   assign chk_rsp_out.block = chk_block_reg;
   assign bus_clk_en_out = clk_en_out_reg;
   assign protect_a_out = prot_a;
   assign protect_b_out = prot_b;
   assign protect_c_out = prot_c;

endmodule // pwg_top

/* verif/pwg_top_asserts.sv */
// Port-level checks of the write guard top
module pwg_top_asserts (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire pwg_pkg::pwg_bus_req_type bus_req_in,
   input wire logic src_clk_run_in,
   input wire pwg_pkg::pwg_chk_req_type chk_req_in,
   input wire logic [31:0] rdata_out,
   input wire pwg_pkg::pwg_chk_rsp_type chk_rsp_out,
   input wire logic [2:0] bus_clk_en_out,
   input wire logic [31:0] protect_a_out,
   input wire logic [31:0] protect_b_out,
   input wire logic [31:0] protect_c_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   wire logic wr_ok = bus_req_in.wr && src_clk_run_in;
   wire logic [11:0] ad = bus_req_in.addr;
   wire logic dbg = chk_req_in.valid && chk_req_in.debug;
   chk_done_a: assert property (
      chk_req_in.valid |=> chk_rsp_out.done) else $error("no answer");
   dbg_pass_a: assert property (
      dbg && chk_req_in.bridge != 2'h3 |=> chk_rsp_out.allow)
      else $error("debug write blocked");
   guard_blk_a: assert property (
      chk_req_in.valid && !chk_req_in.debug && chk_req_in.bridge == 2'h0
      && protect_a_out[chk_req_in.slot] |=> chk_rsp_out.block)
      else $error("protected write passed");
   a_mask_a: assert property (
      (protect_a_out & ~32'h0000007e) == 32'h0) else $error("a spare bit");
   b_mask_a: assert property (
      (protect_b_out & ~32'h0000004e) == 32'h0) else $error("b spare bit");
   a_clear_a: assert property (
      wr_ok && ad == 12'h000 && bus_clk_en_out[0] |=> protect_a_out ==
      ($past(protect_a_out) & ~$past(bus_req_in.wdata)))
      else $error("clear wrong");
   b_set_a: assert property (
      wr_ok && ad == 12'h104 && bus_clk_en_out[1] |=> protect_b_out ==
      ($past(protect_b_out) | ($past(bus_req_in.wdata) & 32'h0000004e)))
      else $error("set wrong");
   rd_back_a: assert property (
      bus_req_in.rd && ad == 12'h004 |=> rdata_out == $past(protect_a_out))
      else $error("read wrong");
   c_gate_a: assert property (
      bus_req_in.wr && ad[11:8] == 4'h2 && !bus_clk_en_out[2]
      |=> $stable(protect_c_out)) else $error("gated write took");
   sleep_hold_a: assert property (
      bus_req_in.wr && !src_clk_run_in |=> $stable(protect_a_out))
      else $error("write while stopped");
   cover property (chk_rsp_out.block);
   cover property (dbg ##1 chk_rsp_out.allow);
   cover property (wr_ok && ad == 12'h204 && bus_clk_en_out[2]);
endmodule // pwg_top_asserts

bind pwg_top pwg_top_asserts u_chk (.core_clk_in(core_clk_in),
   .sys_rst_in(sys_rst_in), .bus_req_in(bus_req_in),
   .src_clk_run_in(src_clk_run_in), .chk_req_in(chk_req_in),
   .rdata_out(rdata_out), .chk_rsp_out(chk_rsp_out),
   .bus_clk_en_out(bus_clk_en_out), .protect_a_out(protect_a_out),
   .protect_b_out(protect_b_out), .protect_c_out(protect_c_out));

/* verif/pwg_bridge_model.sv */
// Bridge-side model raising write check requests
module pwg_bridge_model (
   input wire logic core_clk_in,
   output pwg_pkg::pwg_chk_req_type chk_req_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial chk_req_out = '0;
   task send(input logic [1:0] br, input logic [4:0] sl, input logic d);
      @(posedge core_clk_in);
      chk_req_out <= '{1'b1, br, sl, d};
      @(posedge core_clk_in);
      // Released fields show the inverse
      chk_req_out <= '{1'b0, ~br, ~sl, ~d};
   endtask
endmodule // pwg_bridge_model

/* verif/tb_top.sv */
// Self-checking bench for the peripheral write guard
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic run = 1'b1;
   pwg_pkg::pwg_bus_req_type bus = '0;
   pwg_pkg::pwg_chk_req_type chk;
   pwg_pkg::pwg_chk_rsp_type rsp;
   logic [31:0] rdata, pa, pb, pc;
   logic [2:0] clk_en;
   int checks = 0;
   int bad_count = 0;
   always #2.5 clk = ~clk;
   pwg_top uut (.core_clk_in(clk), .sys_rst_in(rst), .bus_req_in(bus),
      .src_clk_run_in(run), .chk_req_in(chk), .rdata_out(rdata),
      .chk_rsp_out(rsp), .bus_clk_en_out(clk_en), .protect_a_out(pa),
      .protect_b_out(pb), .protect_c_out(pc));
   pwg_bridge_model bm (.core_clk_in(clk), .chk_req_out(chk));
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 cmp(rdata, e);
   endtask
   task ck(input logic [1:0] b, input logic [4:0] s, input logic d,
      input logic [2:0] e);
      bm.send(b, s, d);
      #1 cmp({29'h0, rsp}, {29'h0, e});
   endtask
   task t_reset;
      cmp(pa | pc, 32'h0);
      cmp({29'h0, clk_en}, 32'h3);
      rd(12'h100, 32'h2);
      $display("t_reset end");
   endtask
   task t_bits;
      wr(12'h004, 32'hffffffff);
      rd(12'h000, 32'h7e);
      wr(12'h000, 32'h0);
      wr(12'h004, 32'h0);
      rd(12'h004, 32'h7e);
      wr(12'h000, 32'h10);
      rd(12'h004, 32'h6e);
      $display("t_bits end");
   endtask
   task t_guard;
      ck(2'h0, 5'd5, 1'b0, 3'b101);
      ck(2'h0, 5'd4, 1'b0, 3'b110);
      ck(2'h0, 5'd5, 1'b1, 3'b110);
      ck(2'h1, 5'd1, 1'b0, 3'b101);
      ck(2'h2, 5'd1, 1'b0, 3'b110);
      ck(2'h3, 5'd1, 1'b0, 3'b100);
      $display("t_guard end");
   endtask
   task t_bridge_b;
      wr(12'h104, 32'hffffffff);
      rd(12'h100, 32'h4e);
      wr(12'h100, 32'hc);
      rd(12'h104, 32'h42);
      cmp(pb, 32'h42);
      $display("t_bridge_b end");
   endtask
   task t_gate;
      wr(12'h204, 32'hffffffff);
      rd(12'h200, 32'h0);
      wr(12'h300, 32'h7);
      rd(12'h300, 32'h7);
      wr(12'h204, 32'hffffffff);
      rd(12'h200, 32'h000fff7e);
      wr(12'h300, 32'h3);
      wr(12'h200, 32'hffffffff);
      rd(12'h204, 32'h000fff7e);
      $display("t_gate end");
   endtask
   task t_sleep;
      @(posedge clk);
      run <= 1'b0;
      wr(12'h000, 32'hffffffff);
      rd(12'h000, 32'h6e);
      ck(2'h0, 5'd6, 1'b0, 3'b101);
      @(posedge clk);
      run <= 1'b1;
      wr(12'h000, 32'hffffffff);
      rd(12'h000, 32'h0);
      rd(12'h3fc, 32'h0);
      $display("t_sleep end");
   endtask
   task t_status;
      rd(12'h304, 32'h3);
      rd(12'h308, 32'h2);
      @(posedge clk);
      #1 cmp(rdata, 32'h0);
      wr(12'h304, 32'h1);
      rd(12'h304, 32'h2);
      wr(12'h308, 32'h0);
      rd(12'h308, 32'h0);
      $display("t_status end");
   endtask
   task t_rerun;
      wr(12'h300, 32'h4);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 cmp(pa | pc, 32'h0);
      cmp(pb, 32'h2);
      cmp({29'h0, clk_en}, 32'h3);
      @(posedge clk);
      #1 cmp({29'h0, clk_en}, 32'h3);
      rd(12'h308, 32'h0);
      $display("t_rerun end");
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1;
      t_reset();
      t_bits();
      t_guard();
      t_status();
      t_bridge_b();
      t_gate();
      t_sleep();
      t_rerun();
      print_verdict();
   end
endmodule // tb_top
